// ===== rtl/sds_serial_driver_cfg.sv
`timescale 1ns/1ps
// Notes on behaviour
// - emphasis level comes from low nibble of driver control register
// - thirteen distinct emphasis settings are decoded
// - 0000 none, 0001-0100 deemphasis, 1000-1111 preemphasis up to 14 dB
// - deemphasis keeps full swing on transitions, lowers repeated bits
// - strength bits 5:4: 11 full, 10 three quarters, 01 half
// - spread codes: 000/100 off, then 0.5, 1.5, 2, 1, 3, 4 percent
// - power-up spread default is 001 with pin high, 000 with pin low
// - default pin sampled only at power-up and power-down exit
// - turning spread on or off restarts link until far end relocks
// - 0.5 percent usable at any clock; others limited at high clocks
// - spread settings leave audio stream untouched
// - sawtooth divider value sits in bits 5:0 of register 0x03
module sds_serial_driver_cfg (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic spread_default_pin,
    input wire logic pwdn_b,
    input wire logic far_lock,
    input wire logic [1:0] pclk_band,
    input wire logic lane_mode_4ch,
    input wire logic tx_bit,
    input wire logic audio_bit_in,
    output logic audio_bit_out,
    output logic [4:0] drv_icml_ma,
    output logic [3:0] drv_ipre_ma,
    output logic drv_deemph,
    output logic [1:0] drv_strength,
    output logic [9:0] drv_swing_mv,
    output logic [2:0] spread_code,
    output logic spread_on,
    output logic [5:0] spread_ramp,
    output logic spread_wrap,
    output logic link_restart,
    output logic link_available
);
    // registers
    logic [3:0] emph_ff;
    logic [1:0] strength_ff;
    logic [2:0] spread_ff;
    logic [5:0] sawtooth_divider_ff;
    logic [7:0] rdata_ff;
    logic rvalid_ff;

    // pin synchronisers
    logic strap_s1_ff;
    logic strap_s2_ff;
    logic pwdn_s1_ff;
    logic pwdn_s2_ff;
    logic lock_s1_ff;
    logic lock_s2_ff;
    logic pwdn_prev_ff;

    // strap capture
    logic [1:0] settle_ff;
    logic capture_pend_ff;

    // link sequencing
    sds_pkg::sds_link_t link_ff;
    sds_pkg::sds_link_t nxt_link;
    logic [7:0] hold_ff;
    logic [7:0] nxt_hold;
    logic spread_on_prev_ff;
    logic restart_ff;

    // driver outputs
    logic prev_bit_ff;
    logic [9:0] swing_ff;
    logic [2:0] eff_spread_ff;
    logic audio_ff;

    // emphasis map outputs
    logic [4:0] map_icml;
    logic [3:0] map_ipre;
    logic [9:0] map_max;
    logic [9:0] map_min;
    logic map_deemph;
    logic map_valid;

    function automatic logic ss_active(input logic [2:0] c);
        ss_active = (c != sds_pkg::SS_OFF) && (c != sds_pkg::SS_OFF_ALT);
    endfunction

    function automatic logic [9:0] scale_swing(input logic [9:0] mv, input logic [1:0] s);
        logic [11:0] wide;
        wide = {2'h0, mv};
        case (s)
            sds_pkg::STR_3Q: scale_swing = 10'((wide * 12'h003) >> 2);
            sds_pkg::STR_HALF: scale_swing = 10'(wide >> 1);
            default: scale_swing = mv;
        endcase
    endfunction

    // modulation coefficient per rate and lane mode
    function automatic logic [7:0] mod_coef_of(input logic [2:0] c, input logic four);
        case (c)
            sds_pkg::SS_P5, sds_pkg::SS_1: mod_coef_of = four ? 8'h68 : 8'h50;
            sds_pkg::SS_1P5, sds_pkg::SS_3: mod_coef_of = four ? 8'h98 : 8'h70;
            default: mod_coef_of = four ? 8'hCC : 8'h98;
        endcase
    endfunction

    // address decode
    wire hit_sawtooth_divider = (reg_addr == sds_pkg::SAWTOOTH_OFS);
    wire hit_spread = (reg_addr == sds_pkg::SPREAD_CTRL_OFS);
    wire hit_drv = (reg_addr == sds_pkg::DRV_CTRL_OFS);
    wire hit_status = (reg_addr == sds_pkg::STATUS_OFS);

    wire pwdn_exit = pwdn_s2_ff && !pwdn_prev_ff;
    wire strap_load = capture_pend_ff && (settle_ff == 2'(sds_pkg::STRAP_SETTLE_CYC - 1));
    wire [2:0] strap_code = strap_s2_ff ? sds_pkg::SS_P5 : sds_pkg::SS_OFF;

    // rate limit by pixel clock band, 0.5 percent always allowed
    wire band_ok_all = (pclk_band == sds_pkg::BAND_LOW);
    wire band_ok_mid = (pclk_band == sds_pkg::BAND_MID) &&
        (spread_ff == sds_pkg::SS_1P5 || spread_ff == sds_pkg::SS_1);
    wire rate_ok = !ss_active(spread_ff) || spread_ff == sds_pkg::SS_P5 ||
        band_ok_all || band_ok_mid;
    wire [2:0] nxt_eff_spread = rate_ok ? spread_ff : sds_pkg::SS_P5;

    wire cur_on = ss_active(eff_spread_ff);
    wire on_change = (cur_on != spread_on_prev_ff);

    wire [7:0] status_word = {4'h0, !map_valid,
        !rate_ok, (link_ff == sds_pkg::SDS_LINK_RESTART), (link_ff == sds_pkg::SDS_LINK_UP)};

    wire [7:0] rd_mux = hit_sawtooth_divider ? {2'h0, sawtooth_divider_ff} :
        hit_spread ? {5'h00, spread_ff} :
        hit_drv ? {2'h0, strength_ff, emph_ff} :
        hit_status ? status_word : 8'h00;

    sds_emph_map u_emph_map (
        .code(emph_ff),
        .icml_ma(map_icml),
        .ipre_ma(map_ipre),
        .swing_max_mv(map_max),
        .swing_min_mv(map_min),
        .deemph(map_deemph),
        .code_valid(map_valid)
    );

    sds_sawtooth u_sawtooth (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .run(cur_on),
        .mod_coef(mod_coef_of(eff_spread_ff, lane_mode_4ch)),
        .sawtooth_divider(sawtooth_divider_ff),
        .ramp(spread_ramp),
        .wrap(spread_wrap)
    );

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_s1_ff <= 1'b0;
            strap_s2_ff <= 1'b0;
            pwdn_s1_ff <= 1'b0;
            pwdn_s2_ff <= 1'b0;
            lock_s1_ff <= 1'b0;
            lock_s2_ff <= 1'b0;
            pwdn_prev_ff <= 1'b0;
        end else begin
            strap_s1_ff <= spread_default_pin;
            strap_s2_ff <= strap_s1_ff;
            pwdn_s1_ff <= pwdn_b;
            pwdn_s2_ff <= pwdn_s1_ff;
            lock_s1_ff <= far_lock;
            lock_s2_ff <= lock_s1_ff;
            pwdn_prev_ff <= pwdn_s2_ff;
        end
    end

    // strap pending after reset and after power-down exit
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            capture_pend_ff <= 1'b1;
            settle_ff <= 2'h0;
        end else if (pwdn_exit) begin
            capture_pend_ff <= 1'b1;
            settle_ff <= 2'h0;
        end else if (strap_load) begin
            capture_pend_ff <= 1'b0;
            settle_ff <= 2'h0;
        end else if (capture_pend_ff && pwdn_s2_ff) begin
            settle_ff <= settle_ff + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            emph_ff <= sds_pkg::EMPH_RST;
            strength_ff <= sds_pkg::STRENGTH_RST;
            sawtooth_divider_ff <= sds_pkg::SAWTOOTH_DIVIDER_RST;
        end else if (reg_wr && hit_drv) begin
            emph_ff <= reg_wdata[sds_pkg::EMPH_LSB +: sds_pkg::EMPH_W];
            strength_ff <= reg_wdata[sds_pkg::STRENGTH_LSB +: sds_pkg::STRENGTH_W];
        end else if (reg_wr && hit_sawtooth_divider) begin
            sawtooth_divider_ff <= reg_wdata[sds_pkg::SAWTOOTH_DIVIDER_LSB +: sds_pkg::SAWTOOTH_DIVIDER_W];
        end
    end

    // strap load wins over a write landing in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            spread_ff <= sds_pkg::SPREAD_RST;
        end else if (strap_load) begin
            spread_ff <= strap_code;
        end else if (reg_wr && hit_spread) begin
            spread_ff <= reg_wdata[sds_pkg::SPREAD_LSB +: sds_pkg::SPREAD_W];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= reg_rd ? rd_mux : rdata_ff;
            rvalid_ff <= reg_rd;
        end
    end

    // link sequencing around spread on/off changes
    always_comb begin
        nxt_link = link_ff;
        nxt_hold = hold_ff;
        case (link_ff)
            sds_pkg::SDS_LINK_DOWN: begin
                if (pwdn_s2_ff && !capture_pend_ff) begin
                    nxt_link = sds_pkg::SDS_LINK_RESTART;
                    nxt_hold = 8'h00;
                end
            end
            sds_pkg::SDS_LINK_RESTART: begin
                nxt_hold = hold_ff + 8'h01;
                if (hold_ff == 8'(sds_pkg::RESTART_HOLD_CYC - 1)) begin
                    nxt_link = sds_pkg::SDS_LINK_RELOCK;
                end
            end
            sds_pkg::SDS_LINK_RELOCK: begin
                if (lock_s2_ff) begin
                    nxt_link = sds_pkg::SDS_LINK_UP;
                end
            end
            default: begin
            end
        endcase
        if (link_ff != sds_pkg::SDS_LINK_DOWN && on_change) begin
            nxt_link = sds_pkg::SDS_LINK_RESTART;
            nxt_hold = 8'h00;
        end
        if (!pwdn_s2_ff) begin
            nxt_link = sds_pkg::SDS_LINK_DOWN;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_ff <= sds_pkg::SDS_LINK_DOWN;
            hold_ff <= 8'h00;
            spread_on_prev_ff <= 1'b0;
            restart_ff <= 1'b0;
        end else begin
            link_ff <= nxt_link;
            hold_ff <= nxt_hold;
            spread_on_prev_ff <= cur_on;
            restart_ff <= on_change && (link_ff != sds_pkg::SDS_LINK_DOWN);
        end
    end

    // per-bit swing: transitions full, repeated bits reduced
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_bit_ff <= 1'b0;
            swing_ff <= 10'h000;
            eff_spread_ff <= sds_pkg::SPREAD_RST;
            audio_ff <= 1'b0;
        end else begin
            prev_bit_ff <= tx_bit;
            swing_ff <= scale_swing((tx_bit != prev_bit_ff) ? map_max : map_min,
                strength_ff);
            eff_spread_ff <= nxt_eff_spread;
            audio_ff <= audio_bit_in;
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign audio_bit_out = audio_ff;
    assign drv_icml_ma = map_icml;
    assign drv_ipre_ma = map_ipre;
    assign drv_deemph = map_deemph;
    assign drv_strength = strength_ff;
    assign drv_swing_mv = swing_ff;
    assign spread_code = eff_spread_ff;
    assign spread_on = cur_on;
    assign link_restart = restart_ff;
    assign link_available = (link_ff == sds_pkg::SDS_LINK_UP);
endmodule

// ===== rtl/sds_pkg.sv
package sds_pkg;

    // register offsets
    localparam logic [7:0] SAWTOOTH_OFS = 8'h03;
    localparam logic [7:0] SPREAD_CTRL_OFS = 8'h04;
    localparam logic [7:0] DRV_CTRL_OFS = 8'h05;
    localparam logic [7:0] STATUS_OFS = 8'h07;

    // field positions
    localparam int EMPH_LSB = 0;
    localparam int EMPH_W = 4;
    localparam int STRENGTH_LSB = 4;
    localparam int STRENGTH_W = 2;
    localparam int SPREAD_LSB = 0;
    localparam int SPREAD_W = 3;
    localparam int SAWTOOTH_DIVIDER_LSB = 0;
    localparam int SAWTOOTH_DIVIDER_W = 6;
    localparam int ST_AVAIL_BIT = 0;
    localparam int ST_RESTART_BIT = 1;
    localparam int ST_CLAMP_BIT = 2;
    localparam int ST_BADEMPH_BIT = 3;

    // reset values
    localparam logic [3:0] EMPH_RST = 4'h0;
    localparam logic [1:0] STRENGTH_RST = 2'h3;
    localparam logic [2:0] SPREAD_RST = 3'h0;
    localparam logic [5:0] SAWTOOTH_DIVIDER_RST = 6'h3F;

    // strength codes
    localparam logic [1:0] STR_FULL = 2'h3;
    localparam logic [1:0] STR_3Q = 2'h2;
    localparam logic [1:0] STR_HALF = 2'h1;

    // spread codes
    localparam logic [2:0] SS_OFF = 3'h0;
    localparam logic [2:0] SS_P5 = 3'h1;
    localparam logic [2:0] SS_1P5 = 3'h2;
    localparam logic [2:0] SS_2 = 3'h3;
    localparam logic [2:0] SS_OFF_ALT = 3'h4;
    localparam logic [2:0] SS_1 = 3'h5;
    localparam logic [2:0] SS_3 = 3'h6;
    localparam logic [2:0] SS_4 = 3'h7;

    // pixel clock bands
    localparam logic [1:0] BAND_LOW = 2'h0;
    localparam logic [1:0] BAND_MID = 2'h1;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int RESTART_HOLD_NS = 1000;
    localparam int RESTART_HOLD_CYC =
        (RESTART_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_SETTLE_CYC = 3;

    typedef enum logic [1:0] {
        SDS_LINK_DOWN,
        SDS_LINK_RESTART,
        SDS_LINK_RELOCK,
        SDS_LINK_UP
    } sds_link_t;

endpackage

// ===== rtl/sds_emph_map.sv
`timescale 1ns/1ps
module sds_emph_map (
    input wire logic [3:0] code,
    output logic [4:0] icml_ma,
    output logic [3:0] ipre_ma,
    output logic [9:0] swing_max_mv,
    output logic [9:0] swing_min_mv,
    output logic deemph,
    output logic code_valid
);
    // thirteen settings; unused codes fall back to no emphasis
    always_comb begin
        icml_ma = 5'h10;
        ipre_ma = 4'h0;
        swing_max_mv = 10'h190;
        swing_min_mv = 10'h190;
        deemph = 1'b0;
        code_valid = 1'b1;
        case (code)
            4'h0: begin
            end
            4'h1: begin
                icml_ma = 5'h0F;
                ipre_ma = 4'h1;
                swing_min_mv = 10'h15E;
                deemph = 1'b1;
            end
            4'h2: begin
                icml_ma = 5'h0E;
                ipre_ma = 4'h2;
                swing_min_mv = 10'h12C;
                deemph = 1'b1;
            end
            4'h3: begin
                icml_ma = 5'h0D;
                ipre_ma = 4'h3;
                swing_min_mv = 10'h0FA;
                deemph = 1'b1;
            end
            4'h4: begin
                icml_ma = 5'h0C;
                ipre_ma = 4'h4;
                swing_min_mv = 10'h0C8;
                deemph = 1'b1;
            end
            4'h8: begin
                ipre_ma = 4'h1;
                swing_max_mv = 10'h1A9;
                swing_min_mv = 10'h177;
            end
            4'h9: begin
                ipre_ma = 4'h2;
                swing_max_mv = 10'h1C2;
                swing_min_mv = 10'h15E;
            end
            4'hA: begin
                ipre_ma = 4'h3;
                swing_max_mv = 10'h1DB;
                swing_min_mv = 10'h145;
            end
            4'hB: begin
                ipre_ma = 4'h4;
                swing_max_mv = 10'h1F4;
                swing_min_mv = 10'h12C;
            end
            4'hC: begin
                icml_ma = 5'h0F;
                ipre_ma = 4'h5;
                swing_max_mv = 10'h1F4;
                swing_min_mv = 10'h0FA;
            end
            4'hD: begin
                icml_ma = 5'h0E;
                ipre_ma = 4'h6;
                swing_max_mv = 10'h1F4;
                swing_min_mv = 10'h0C8;
            end
            4'hE: begin
                icml_ma = 5'h0D;
                ipre_ma = 4'h7;
                swing_max_mv = 10'h1F4;
                swing_min_mv = 10'h096;
            end
            4'hF: begin
                icml_ma = 5'h0C;
                ipre_ma = 4'h8;
                swing_max_mv = 10'h1F4;
                swing_min_mv = 10'h064;
            end
            default: begin
                code_valid = 1'b0;
            end
        endcase
    end
endmodule

// ===== rtl/sds_sawtooth.sv
`timescale 1ns/1ps
module sds_sawtooth (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [7:0] mod_coef,
    input wire logic [5:0] sawtooth_divider,
    output logic [5:0] ramp,
    output logic wrap
);
    logic [7:0] step_ff;
    logic [5:0] ramp_ff;
    logic wrap_ff;
    logic [7:0] nxt_step;
    logic [5:0] nxt_ramp;
    logic nxt_wrap;
    wire step_done = (step_ff >= mod_coef - 8'h01);
    wire [5:0] ramp_top = (sawtooth_divider == 6'h00) ? 6'h00 : sawtooth_divider - 6'h01;
    wire ramp_done = (ramp_ff >= ramp_top);

    // ramp advances once per modulation-coefficient period
    always_comb begin
        nxt_step = step_done ? 8'h00 : step_ff + 8'h01;
        nxt_ramp = ramp_ff;
        nxt_wrap = 1'b0;
        if (!run) begin
            nxt_step = 8'h00;
            nxt_ramp = 6'h00;
        end else if (step_done) begin
            nxt_ramp = ramp_done ? 6'h00 : ramp_ff + 6'h01;
            nxt_wrap = ramp_done;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            step_ff <= 8'h00;
            ramp_ff <= 6'h00;
            wrap_ff <= 1'b0;
        end else begin
            step_ff <= nxt_step;
            ramp_ff <= nxt_ramp;
            wrap_ff <= nxt_wrap;
        end
    end

    assign ramp = ramp_ff;
    assign wrap = wrap_ff;
endmodule

// ===== tb/sds_serial_driver_cfg_props.sv
`timescale 1ns/1ps
module sds_serial_driver_cfg_props (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [1:0] pclk_band,
    input wire logic audio_bit_in,
    input wire logic audio_bit_out,
    input wire logic [4:0] drv_icml_ma,
    input wire logic [3:0] drv_ipre_ma,
    input wire logic drv_deemph,
    input wire logic [1:0] drv_strength,
    input wire logic [2:0] spread_code,
    input wire logic spread_on,
    input wire logic link_restart,
    input wire logic link_available
);
    logic [1:0] wr_strength;
    logic band_high;
    assign wr_strength = reg_wdata[5:4];
    assign band_high = pclk_band[1];
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_onoff;
        $changed(spread_on) && link_available;
    endsequence
    sequence s_quiet;
        link_available && !reg_wr && $stable(pclk_band) ##1
            link_available && !reg_wr && $stable(pclk_band);
    endsequence
    property p_rvalid;
        reg_rd |=> reg_rvalid;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer missing");
    property p_rdata;
        reg_rd && !reg_wr && reg_addr == sds_pkg::DRV_CTRL_OFS |=>
            reg_rdata[5:4] == $past(drv_strength) && reg_rdata[7:6] == 2'h0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("strength readback wrong");
    property p_strength;
        reg_wr && reg_addr == sds_pkg::DRV_CTRL_OFS |=> drv_strength == $past(wr_strength);
    endproperty
    a_strength: assert property (p_strength) else $error("strength not applied");
    property p_deemph;
        drv_deemph |-> {1'b0, drv_icml_ma} + {2'h0, drv_ipre_ma} == 6'h10;
    endproperty
    a_deemph: assert property (p_deemph) else $error("deemphasis currents wrong");
    property p_spread_on;
        spread_on == (spread_code[1:0] != 2'h0);
    endproperty
    a_spread_on: assert property (p_spread_on) else $error("spread on decode wrong");
    property p_clamp;
        $past(band_high) && $past(band_high, 2) && spread_on |-> spread_code == sds_pkg::SS_P5;
    endproperty
    a_clamp: assert property (p_clamp) else $error("fast clock rate not clamped");
    property p_restart;
        s_onoff |=> link_restart && !link_available;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart on spread toggle");
    property p_cause;
        link_restart |-> $past(spread_on) != $past(spread_on, 2);
    endproperty
    a_cause: assert property (p_cause) else $error("restart without toggle");
    property p_strap;
        s_quiet |=> $stable(spread_code);
    endproperty
    a_strap: assert property (p_strap) else $error("spread changed while idle");
    property p_audio;
        $past(rst_b) |-> audio_bit_out == $past(audio_bit_in);
    endproperty
    a_audio: assert property (p_audio) else $error("audio stream disturbed");
endmodule

bind sds_serial_driver_cfg sds_serial_driver_cfg_props props (
    .ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .pclk_band, .audio_bit_in, .audio_bit_out, .drv_icml_ma, .drv_ipre_ma, .drv_deemph,
    .drv_strength, .spread_code, .spread_on, .link_restart, .link_available
);

// ===== tb/sds_far_end.sv
`timescale 1ns/1ps
module sds_far_end (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic drop,
    input wire logic slow,
    output logic far_lock
);
    // far end never spreads; it only relocks after a delay
    logic [7:0] wait_ff;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_ff <= 8'h19;
        end else if (drop) begin
            wait_ff <= slow ? 8'h3C : 8'h19;
        end else if (wait_ff != 8'h00) begin
            wait_ff <= wait_ff - 8'h01;
        end
    end
    assign far_lock = (wait_ff == 8'h00);
endmodule

// ===== tb/sds_serial_driver_cfg_test.sv
`timescale 1ns/1ps
module sds_serial_driver_cfg_test;
    logic ref_clk = 1'b0;
    logic rst_b, reg_wr, reg_rd, spread_default_pin, pwdn_b, lane_mode_4ch, tx_bit, slow;
    logic audio_bit_in, audio_bit_out, reg_rvalid, drv_deemph, spread_on, spread_wrap;
    logic link_restart, link_available, far_lock;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] pclk_band, drv_strength;
    logic [4:0] drv_icml_ma;
    logic [3:0] drv_ipre_ma;
    logic [9:0] drv_swing_mv;
    logic [2:0] spread_code;
    logic [5:0] spread_ramp;
    logic [31:0] lfsr = 32'h000137DA;
    int failures = 0;
    int cmp_count = 0;
    int restarts = 0;
    int rm [256];
    int icml [16] = '{16, 15, 14, 13, 12, 16, 16, 16, 16, 16, 16, 16, 15, 14, 13, 12};
    int ipre [16] = '{0, 1, 2, 3, 4, 0, 0, 0, 1, 2, 3, 4, 5, 6, 7, 8};
    int smax [16] = '{400, 400, 400, 400, 400, 400, 400, 400,
                      425, 450, 475, 500, 500, 500, 500, 500};
    int smin [16] = '{400, 350, 300, 250, 200, 400, 400, 400,
                      375, 350, 325, 300, 250, 200, 150, 100};

    sds_serial_driver_cfg dut (
        .ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
        .spread_default_pin, .pwdn_b, .far_lock, .pclk_band, .lane_mode_4ch, .tx_bit,
        .audio_bit_in, .audio_bit_out, .drv_icml_ma, .drv_ipre_ma, .drv_deemph,
        .drv_strength, .drv_swing_mv, .spread_code, .spread_on, .spread_ramp,
        .spread_wrap, .link_restart, .link_available
    );
    sds_far_end far (.ref_clk, .rst_b, .drop(link_restart || !pwdn_b), .slow, .far_lock);

    always #(sds_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        if (link_available === 1'b1) begin
            chk("audio", {9'h000, audio_bit_in}, {9'h000, audio_bit_out});
        end
        audio_bit_in <= lfsr[5];
    end
    always @(negedge ref_clk) begin
        if (link_restart === 1'b1) restarts++;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        if (a == 8'h03 || a == 8'h05) rm[a] = d & 8'h3F;
        if (a == 8'h04) rm[a] = d & 8'h07;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk("rvalid", 10'h001, {9'h000, reg_rvalid});
        chk("rdata", 10'(rm[a]), {2'h0, reg_rdata});
    endtask

    task automatic wait_up;
        int n;
        n = 0;
        while (link_available !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        chk("link up", 10'h001, {9'h000, link_available});
    endtask

    task automatic wrap_up;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        $display("BAD watchdog expected finish seen hang");
        wrap_up();
    end

    initial begin
        int c, s, on, pon, e, exp_rs;
        logic nt;
        logic [9:0] exp_sw;
        rst_b = 1'b0;
        {reg_wr, reg_rd, tx_bit, slow, lane_mode_4ch} = 5'h00;
        {reg_addr, reg_wdata, pclk_band} = 18'h00000;
        spread_default_pin = 1'b1;
        pwdn_b = 1'b1;
        rm[3] = 'h3F;
        rm[4] = 1;
        rm[5] = 'h30;
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        wait_up();
        exp_rs = restarts;
        chk("strap", 10'h001, {7'h00, spread_code});
        rd(8'h05);
        rd(8'h04);
        wr(8'h03, 8'hC8);
        rd(8'h03);
        wr(8'h10, 8'h5A);
        wr(8'h07, 8'hFF);
        rd(8'h10);
        rm[7] = 1;
        rd(8'h07);
        for (e = 0; e < 16; e++) begin
            lfsr = lfsr_next(lfsr);
            s = lfsr[1:0];
            lane_mode_4ch = lfsr[2];
            wr(8'h05, {lfsr[7:6], lfsr[1:0], e[3:0]});
            chk("icml", 10'(icml[e]), {5'h00, drv_icml_ma});
            chk("ipre", 10'(ipre[e]), {6'h00, drv_ipre_ma});
            chk("deemph", {9'h000, e >= 1 && e <= 4}, {9'h000, drv_deemph});
            chk("strength", 10'(s), {8'h00, drv_strength});
            rd(8'h05);
            for (c = 0; c < 5; c++) begin
                @(negedge ref_clk);
                if (c > 0) chk("swing", exp_sw, drv_swing_mv);
                lfsr = lfsr_next(lfsr);
                nt = lfsr[0];
                on = (nt != tx_bit) ? smax[e] : smin[e];
                exp_sw = 10'(s == 2 ? on * 3 / 4 : (s == 1 ? on / 2 : on));
                tx_bit = nt;
            end
        end
        chk("no restart", 10'(exp_rs), 10'(restarts));
        pon = 1;
        for (c = 0; c < 8; c++) begin
            on = (c % 4) != 0;
            slow = c[0];
            wr(8'h04, 8'(c));
            repeat (3) @(negedge ref_clk);
            chk("spread code", 10'(c), {7'h00, spread_code});
            chk("spread on", 10'(on), {9'h000, spread_on});
            if (on != pon) begin
                exp_rs++;
                chk("link down", 10'h000, {9'h000, link_available});
                wait_up();
            end
            chk("restarts", 10'(exp_rs), 10'(restarts));
            pon = on;
        end
        for (c = 0; c < 3; c++) begin
            pclk_band = (c == 0) ? 2'h2 : 2'h1;
            wr(8'h04, 8'(7 - c));
            repeat (3) @(negedge ref_clk);
            chk("clamp", (c == 2) ? 10'h005 : 10'h001, {7'h00, spread_code});
        end
        pclk_band = 2'h0;
        spread_default_pin = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk("pin ignored", 10'h005, {7'h00, spread_code});
        rd(8'h04);
        while (spread_wrap !== 1'b1) @(negedge ref_clk);
        chk("ramp at wrap", 10'h000, {4'h0, spread_ramp});
        c = 0;
        do begin
            @(negedge ref_clk);
            c++;
        end while (spread_wrap !== 1'b1 && c < 1000);
        chk("wrap period", 10'((lane_mode_4ch ? 104 : 80) * 8), 10'(c));
        pwdn_b = 1'b0;
        repeat (10) @(negedge ref_clk);
        pwdn_b = 1'b1;
        wait_up();
        rm[4] = 0;
        chk("strap reload", 10'h000, {7'h00, spread_code});
        rd(8'h04);
        wrap_up();
    end
endmodule
